// ===== src/fog_pkg.sv
// Purpose: Constants for the fail output and alternate pin block.
// Assumes: 125 MHz system clock.
// Notes: Register offsets are word indices on a plain register port.
package fog_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned BLINK_MHZ = 1250; // 1.25 Hz in millihertz.
    localparam int unsigned PWM_HZ = 100;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (BLINK_MHZ * 2) * 1000;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
    localparam int unsigned UV_LIMIT = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_GPIO = 4'h2;
    localparam logic [3:0] ADDR_WAKE = 4'h3;
    localparam logic [3:0] ADDR_LVL = 4'h4;
    // Control register fields.
    localparam int CTRL_FORCE = 0;
    localparam int CTRL_OVRST = 1;
    localparam int CTRL_DC_LO = 2;
    // Status register fields; write one to clear the fail flag.
    localparam int STAT_FAIL = 0;
    localparam int STAT_WDF = 1;
    localparam int STAT_WDCNT = 2;
    typedef enum logic [5:0] {
        FOG_NORMAL = 6'h01,
        FOG_STOP = 6'h02,
        FOG_SLEEP = 6'h04,
        FOG_RESTART = 6'h08,
        FOG_SAFE = 6'h10,
        FOG_INIT = 6'h20
    } fog_mode_t;
    // Pin function per alternate pin.
    localparam logic [2:0] PF_FAIL = 3'h0;
    localparam logic [2:0] PF_OFF = 3'h1;
    localparam logic [2:0] PF_WAKE = 3'h2;
    localparam logic [2:0] PF_LOW = 3'h3;
    localparam logic [2:0] PF_HIGH = 3'h4;
endpackage

// ===== src/fog_fail_out.sv
// Purpose: Fail output logic with blink, dimmed PWM and alternate pin use.
// Assumes: Mode and failure events come from the chip state logic, synchronous.
// Notes: Open-drain pins: output enable low means pin pulled low.
// Behaviour
// - three active-low open-drain fail outputs together
// - watchdog fails trip on 2nd (cfg3/4) or 1st
// - thermal and regulator short trip outputs
// - overvoltage trips only with reset enable
// - four consecutive undervoltages trip outputs
// - trip requests safe state mode, watchdog per config
// - fail flag reports output activation
// - force bit independent of failure flags
// - force cleared by write without watchdog
// - release needs no cause and flag clear
// - watchdog flag cleared on kick/sleep/non-watchdog cause/stop-off
// - config 2 first watchdog fail sets no fail flag
// - static low and 1.25 Hz blink
// - dimmed 100 Hz PWM default 20 percent
// - duty select 20, 10, 5, 2.5 percent
// - pins two and three default to fail function
// - wake pin events recorded in wake status
// - switch pins give no extra diagnostics
// - live pin levels shown in normal/stop
// - fail pins fixed in stop/sleep, active safe
// - wake/switch pin behaviour per mode; normal-only config
// - restart exit resumes function, fail stays active
`timescale 1ns/1ps
`default_nettype none
module fog_fail_out
    import fog_pkg::*;
#(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
    parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC
)
(
    input wire logic clk_i, // System clock.
    input wire logic reset_i, // Asynchronous reset, active high.
    input wire logic [3:0] addr_i, // Register index.
    input wire logic [7:0] wdata_i, // Write data.
    input wire logic wr_i, // Write strobe.
    input wire logic rd_i, // Read strobe.
    output logic [7:0] rdata_o, // Read data, cycle after read.
    input wire logic [5:0] mode_i, // Chip mode, one-hot.
    input wire logic [1:0] hw_cfg_i, // Hardware config 1..4 as 0..3.
    input wire logic watchdog_fail_flag_i, // Watchdog trigger failure pulse.
    input wire logic wd_ok_i, // Successful watchdog trigger pulse.
    input wire logic wd_off_stop_i, // Watchdog disabled in stop mode.
    input wire logic thermal_shutdown_second_level_i, // Second level thermal shutdown level.
    input wire logic short_i, // Main regulator shorted level.
    input wire logic ov_i, // Main regulator overvoltage level.
    input wire logic uv_event_i, // Undervoltage event pulse.
    input wire logic uv_ok_i, // Regulator recovered pulse; breaks sequence.
    input wire logic [1:0] pin_in_i, // Sensed level of pins two and three.
    output logic safe_req_o, // Request to enter safe state mode.
    output logic [2:0] fail_oe_n_o, // Fail pins, low pulls pin low.
    output logic [1:0] hs_drive_o, // High-side switch on for pins two, three.
    output logic [1:0] wake_o // Wake event pulse for pins two, three.
);
    fog_mode_t mode;
    assign mode = fog_mode_t'(mode_i);

    logic fail_q, wdf_q, force_q, ovrst_q;
    logic [1:0] wdcnt_q;
    logic [1:0] dc_q;
    logic [2:0] uvcnt_q;
    logic [5:0] gpio_q;
    logic [1:0] wk_stat_q;
    logic [1:0] lvl_q;
    logic [1:0] pin_prev_q;
    logic [31:0] blink_cnt_q;
    logic blink_q;
    logic [31:0] pwm_cnt_q;
    logic active_q;

    function automatic logic [2:0] pf(input logic [5:0] g, input int i);
        pf = (i == 0) ? g[2:0] : g[5:3];
    endfunction

    // Causes other than the watchdog.
    logic cause_now, wd_trip, wd_sets_flag, wd_to_safe, wr_ctrl, wr_stat;
    assign cause_now = thermal_shutdown_second_level_i || short_i || (ov_i && ovrst_q)
        || (uv_event_i && uvcnt_q == 3'(UV_LIMIT - 1));
    // Configs 3 and 4 trip on second failure, 1 and 2 on the first.
    assign wd_trip = watchdog_fail_flag_i && (hw_cfg_i[1] ? (wdcnt_q != 2'h0) : 1'b1);
    assign wd_sets_flag = wd_trip && !(hw_cfg_i == 2'h1 && wdcnt_q == 2'h0);
    assign wd_to_safe = wd_trip && hw_cfg_i != 2'h1;
    assign wr_ctrl = wr_i && addr_i == ADDR_CTRL;
    assign wr_stat = wr_i && addr_i == ADDR_STAT;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            uvcnt_q <= 3'h0;
        else if (uv_ok_i)
            uvcnt_q <= 3'h0;
        else if (uv_event_i && uvcnt_q != 3'(UV_LIMIT))
            uvcnt_q <= uvcnt_q + 3'h1;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            wdcnt_q <= 2'h0;
        else if (watchdog_fail_flag_i && wdcnt_q != 2'h3)
            wdcnt_q <= wdcnt_q + 2'h1;
        else if (wd_ok_i)
            wdcnt_q <= 2'h0;
    end

    // Set wins over clear on both flags.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            wdf_q <= 1'b0;
        else if (watchdog_fail_flag_i)
            wdf_q <= 1'b1;
        else if (wd_ok_i || mode == FOG_SLEEP || (cause_now && !wd_trip)
                 || (mode == FOG_STOP && wd_off_stop_i))
            wdf_q <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            fail_q <= 1'b0;
        else if (cause_now || wd_sets_flag)
            fail_q <= 1'b1;
        else if (wr_stat && wdata_i[STAT_FAIL] && !wdf_q && !thermal_shutdown_second_level_i && !short_i)
            fail_q <= 1'b0;
    end

    // Output activity follows cause and flag; config 2 first fail drives pins only.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            active_q <= 1'b0;
        else if (cause_now || wd_trip)
            active_q <= 1'b1;
        else if (!fail_q && !wdf_q && !thermal_shutdown_second_level_i && !short_i && mode == FOG_NORMAL)
            active_q <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            safe_req_o <= 1'b0;
        else
            safe_req_o <= cause_now || wd_to_safe;
    end

    // Configuration writes only land in normal mode.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            force_q <= 1'b0;
            ovrst_q <= 1'b0;
            dc_q <= 2'h0;
            gpio_q <= {PF_FAIL, PF_FAIL};
        end
        else if (wr_i && mode == FOG_NORMAL)
        begin
            if (wr_ctrl)
            begin
                force_q <= wdata_i[CTRL_FORCE];
                ovrst_q <= wdata_i[CTRL_OVRST];
                dc_q <= wdata_i[CTRL_DC_LO+:2];
            end
            if (addr_i == ADDR_GPIO)
                gpio_q <= wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b0;
        end
        else if (blink_cnt_q >= BLINK_HALF - 1)
        begin
            blink_cnt_q <= 32'h0;
            blink_q <= !blink_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 32'h1;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pwm_cnt_q <= 32'h0;
        else if (pwm_cnt_q >= PWM_PERIOD - 1)
            pwm_cnt_q <= 32'h0;
        else
            pwm_cnt_q <= pwm_cnt_q + 32'h1;
    end

    // 20 % is one fifth; each step halves it.
    logic [31:0] pwm_on;
    assign pwm_on = (PWM_PERIOD / 5) >> dc_q;

    logic drive_fail;
    assign drive_fail = active_q || force_q;
    logic [1:0] lvl_en;
    assign lvl_en = {2{mode == FOG_NORMAL || mode == FOG_STOP}};

    // Switch pins are off in restart and safe state; no diagnostics kept.
    logic sw_ok;
    assign sw_ok = mode != FOG_RESTART && mode != FOG_SAFE;

    logic [2:0] oe_n_d;
    logic [1:0] hs_d;
    always_comb
    begin
        oe_n_d = 3'h7;
        hs_d = 2'h0;
        oe_n_d[0] = !drive_fail;
        for (int i = 0; i < 2; i++)
        begin
            case (pf(gpio_q, i))
                PF_FAIL:
                    if (drive_fail)
                        oe_n_d[i+1] = (i == 0) ? blink_q : !(pwm_cnt_q < pwm_on);
                PF_LOW:
                    oe_n_d[i+1] = !sw_ok;
                PF_HIGH:
                    hs_d[i] = sw_ok;
                default:
                    oe_n_d[i+1] = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            fail_oe_n_o <= 3'h7;
            hs_drive_o <= 2'h0;
        end
        else
        begin
            fail_oe_n_o <= oe_n_d;
            hs_drive_o <= hs_d;
        end
    end

    // Wake pins: edge of either direction, off in safe state mode.
    logic [1:0] wk_d;
    always_comb
    begin
        wk_d = 2'h0;
        for (int i = 0; i < 2; i++)
            wk_d[i] = pf(gpio_q, i) == PF_WAKE && mode != FOG_SAFE
                && pin_in_i[i] != pin_prev_q[i];
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_prev_q <= 2'h3;
            wake_o <= 2'h0;
            lvl_q <= 2'h0;
        end
        else
        begin
            pin_prev_q <= pin_in_i;
            wake_o <= wk_d;
            lvl_q <= lvl_en & pin_in_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            wk_stat_q <= 2'h0;
        else
            wk_stat_q <= wk_d | (wk_stat_q
                & ~((wr_i && addr_i == ADDR_WAKE) ? wdata_i[1:0] : 2'h0));
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_o <= 8'h0;
        else if (rd_i)
            case (addr_i)
                ADDR_CTRL: rdata_o <= {4'h0, dc_q, ovrst_q, force_q};
                ADDR_STAT: rdata_o <= {4'h0, wdcnt_q, wdf_q, fail_q};
                ADDR_GPIO: rdata_o <= {2'h0, gpio_q};
                ADDR_WAKE: rdata_o <= {6'h0, wk_stat_q};
                ADDR_LVL: rdata_o <= {6'h0, lvl_q};
                default: rdata_o <= 8'h0;
            endcase
        else
            rdata_o <= 8'h0;
    end

    a_fail_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
        (thermal_shutdown_second_level_i || short_i) |=> fail_q)
        else $error("fail flag not set on thermal or short");
    a_ov_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (ov_i && !ovrst_q && !thermal_shutdown_second_level_i && !short_i && !uv_event_i && !watchdog_fail_flag_i
         && !fail_q) |=> !fail_q)
        else $error("overvoltage tripped without enable");
    a_static_low: assert property (@(posedge clk_i) disable iff (reset_i)
        force_q |=> !fail_oe_n_o[0])
        else $error("static fail pin not low when forced");
    a_safe_req: assert property (@(posedge clk_i) disable iff (reset_i)
        (thermal_shutdown_second_level_i || short_i) |=> safe_req_o)
        else $error("no safe state request on cause");
    a_wdf_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == FOG_SLEEP && !watchdog_fail_flag_i) |=> !wdf_q)
        else $error("watchdog flag not cleared in sleep");
    a_cfg_locked: assert property (@(posedge clk_i) disable iff (reset_i)
        mode != FOG_NORMAL |=> $stable(gpio_q))
        else $error("config changed outside normal");
    a_uv_fourth: assert property (@(posedge clk_i) disable iff (reset_i)
        (uv_event_i && uvcnt_q == 3'h3 && !uv_ok_i) |=> fail_q && safe_req_o)
        else $error("fourth undervoltage did not trip");
    a_switch_off: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == FOG_SAFE || mode == FOG_RESTART) |=> hs_drive_o == 2'h0)
        else $error("high side on in restart or safe state");

    // A trip takes two flops to reach the pins: the activity flag, then the output flop.
    sequence s_hard_cause;
        thermal_shutdown_second_level_i || short_i;
    endsequence

    // A force clear with nothing pending must release the pin without a watchdog kick.
    sequence s_force_off;
        wr_ctrl && mode == FOG_NORMAL && !wdata_i[CTRL_FORCE]
            && !active_q && !cause_now && !wd_trip;
    endsequence

    a_trip_path: assert property (@(posedge clk_i) disable iff (reset_i)
        s_hard_cause |=> active_q ##1 !fail_oe_n_o[0])
        else $error("cause did not reach the static pin");
    a_force_release: assert property (@(posedge clk_i) disable iff (reset_i)
        s_force_off |=> !force_q ##1 fail_oe_n_o[0])
        else $error("forced outputs did not release");
    a_cfg34_first: assert property (@(posedge clk_i) disable iff (reset_i)
        (watchdog_fail_flag_i && hw_cfg_i[1] && wdcnt_q == 2'h0 && !active_q && !cause_now)
        |=> !active_q)
        else $error("first watchdog fail tripped in config 3 or 4");
    a_cfg2_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        (watchdog_fail_flag_i && hw_cfg_i == 2'h1 && wdcnt_q == 2'h0 && !fail_q && !cause_now)
        |=> !fail_q)
        else $error("first watchdog fail set the flag in config 2");
    a_cfg2_safe: assert property (@(posedge clk_i) disable iff (reset_i)
        (watchdog_fail_flag_i && hw_cfg_i == 2'h1 && !cause_now) |=> !safe_req_o)
        else $error("config 2 watchdog fail requested safe state");
    a_release_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (active_q && fail_q) |=> active_q)
        else $error("fail outputs released with flag still set");
    a_wd_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
        watchdog_fail_flag_i |=> wdf_q)
        else $error("watchdog flag lost a same-cycle set");
    a_fixed_stop: assert property (@(posedge clk_i) disable iff (reset_i)
        ((mode == FOG_STOP || mode == FOG_SLEEP) && drive_fail) |=> !fail_oe_n_o[0])
        else $error("static fail pin not held in stop or sleep");
    a_blink_pin: assert property (@(posedge clk_i) disable iff (reset_i)
        (drive_fail && pf(gpio_q, 0) == PF_FAIL) |=> fail_oe_n_o[1] == $past(blink_q))
        else $error("blink pin does not follow the blink phase");
    a_wake_safe: assert property (@(posedge clk_i) disable iff (reset_i)
        mode == FOG_SAFE |=> wake_o == 2'h0)
        else $error("wake pulse in safe state");
    a_lvl_hidden: assert property (@(posedge clk_i) disable iff (reset_i)
        !(mode == FOG_NORMAL || mode == FOG_STOP) |=> lvl_q == 2'h0)
        else $error("pin levels shown outside normal or stop");
    a_ls_off: assert property (@(posedge clk_i) disable iff (reset_i)
        (pf(gpio_q, 0) == PF_LOW && (mode == FOG_RESTART || mode == FOG_SAFE))
        |=> fail_oe_n_o[1])
        else $error("low-side switch on in restart or safe state");
endmodule
`default_nettype wire

// ===== test/fog_load_model.sv
// Purpose: Lamp and pull-up load seen by alternate pins two and three.
// Assumes: Pins idle high through the external pull-up when nobody pulls low.
// Notes: An external switch may pull a pin low to make wake edges.
`timescale 1ns/1ps
`default_nettype none
module fog_load_model
(
    input wire logic [1:0] oe_n_i, // Open-drain enables, low pulls the pin.
    input wire logic [1:0] hs_i, // High-side drive per pin.
    input wire logic [1:0] ext_low_i, // External switch pulling low.
    output logic [1:0] level_o // Resolved pin level.
);
    // The pull-up wins when no party drives, so a released pin never shows a stale value.
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            // A driven high side overpowers the weak external switch.
            level_o[i] = (!oe_n_i[i] || (ext_low_i[i] && !hs_i[i])) ? 1'b0 : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== test/fail_output_and_alt_gpio_tb.sv
// Purpose: Self-checking bench for the fail output and alternate pin block.
// Assumes: Short blink and PWM periods set through parameters.
// Notes: Timing counts are measured over whole periods, so phase does not matter.
`timescale 1ns/1ps
`default_nettype none
module fail_output_and_alt_gpio_tb;
    import fog_pkg::*;
    typedef struct {logic [2:0] cause; logic ovrst; logic trip;} fog_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [5:0] mode_i = FOG_NORMAL;
    logic [1:0] hw_cfg_i = 2'h0;
    logic watchdog_fail_flag_i = 1'b0, wd_ok_i = 1'b0, wd_off_stop_i = 1'b0, uv_event_i = 1'b0;
    logic uv_ok_i = 1'b0, thermal_shutdown_second_level_i = 1'b0, short_i = 1'b0, ov_i = 1'b0;
    logic [1:0] ext_low = 2'h0, pin_lvl, hs_drive_o, wake_o;
    logic [7:0] rdata_o, rd;
    logic safe_req_o;
    logic [2:0] fail_oe_n_o;
    int err_count = 0, n_checks = 0, c;
    fog_row_t rows [4] = '{'{3'b001, 1'b0, 1'b1}, '{3'b010, 1'b0, 1'b1},
        '{3'b100, 1'b1, 1'b1}, '{3'b100, 1'b0, 1'b0}};
    logic [3:0] c_addr [5] = '{ADDR_CTRL, ADDR_STAT, ADDR_GPIO, ADDR_WAKE, 4'hf};
    fog_fail_out #(.BLINK_HALF(10), .PWM_PERIOD(200)) uut (.clk_i(clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .mode_i(mode_i), .hw_cfg_i(hw_cfg_i), .watchdog_fail_flag_i(watchdog_fail_flag_i), .wd_ok_i(wd_ok_i),
        .wd_off_stop_i(wd_off_stop_i), .thermal_shutdown_second_level_i(thermal_shutdown_second_level_i), .short_i(short_i), .ov_i(ov_i),
        .uv_event_i(uv_event_i), .uv_ok_i(uv_ok_i), .pin_in_i(pin_lvl),
        .safe_req_o(safe_req_o), .fail_oe_n_o(fail_oe_n_o), .hs_drive_o(hs_drive_o),
        .wake_o(wake_o));
    fog_load_model load (.oe_n_i(fail_oe_n_o[2:1]), .hs_i(hs_drive_o), .ext_low_i(ext_low),
        .level_o(pin_lvl));
    always #4 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        reset_i <= 1'b1;
        mode_i <= FOG_NORMAL;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        wait_cyc(1);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        rd = rdata_o;
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        case (k)
            0: watchdog_fail_flag_i <= 1'b1;
            1: wd_ok_i <= 1'b1;
            2: uv_event_i <= 1'b1;
            default: uv_ok_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {watchdog_fail_flag_i, wd_ok_i, uv_event_i, uv_ok_i} <= 4'h0;
    endtask
    task automatic lows(input int b, input int n);
        c = 0;
        repeat (n)
        begin
            @(posedge clk_i);
            #1;
            if (fail_oe_n_o[b] === 1'b0)
                c++;
        end
    endtask
    initial
    begin
        // About sixteen times the expected run covers every test with margin.
        repeat (20000) @(posedge clk_i);
        err_count++;
        stop_test();
    end
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            do_reset();
            wr_reg(ADDR_CTRL, {6'h00, rows[i].ovrst, 1'b0});
            {ov_i, short_i, thermal_shutdown_second_level_i} <= rows[i].cause;
            wait_cyc(4);
            chk({7'h0, fail_oe_n_o[0]}, {7'h0, ~rows[i].trip});
            chk({7'h0, safe_req_o}, {7'h0, rows[i].trip});
            rd_reg(ADDR_STAT);
            chk({7'h0, rd[STAT_FAIL]}, {7'h0, rows[i].trip});
            {ov_i, short_i, thermal_shutdown_second_level_i} <= 3'h0;
            wr_reg(ADDR_STAT, 8'h01);
            wait_cyc(4);
            chk({5'h0, fail_oe_n_o}, 8'h07);
        end
        $display("test causes done");
        do_reset();
        chk({5'h0, fail_oe_n_o}, 8'h07);
        chk({3'h0, hs_drive_o, wake_o, safe_req_o}, 8'h00);
        foreach (c_addr[i])
        begin
            rd_reg(c_addr[i]);
            chk(rd, 8'h00);
        end
        $display("test reset done");
        for (int dc = 0; dc < 4; dc++)
        begin
            do_reset();
            wr_reg(ADDR_CTRL, {4'h0, dc[1:0], 2'b01});
            wait_cyc(4);
            chk({7'h0, fail_oe_n_o[0]}, 8'h00);
            lows(2, 200);
            chk(c[7:0], 8'd40 >> dc);
            lows(1, 20);
            chk(c[7:0], 8'd10);
            rd_reg(ADDR_STAT);
            chk({7'h0, rd[STAT_FAIL]}, 8'h00);
            wr_reg(ADDR_CTRL, 8'h00);
            wait_cyc(4);
            chk({5'h0, fail_oe_n_o}, 8'h07);
        end
        $display("test duty done");
        do_reset();
        repeat (3) pulse(2);
        pulse(3);
        repeat (3) pulse(2);
        wait_cyc(4);
        chk({7'h0, fail_oe_n_o[0]}, 8'h01);
        pulse(2);
        wait_cyc(4);
        chk({7'h0, fail_oe_n_o[0]}, 8'h00);
        $display("test undervoltage done");
        do_reset();
        hw_cfg_i <= 2'h2;
        pulse(0);
        wait_cyc(4);
        chk({7'h0, fail_oe_n_o[0]}, 8'h01);
        pulse(0);
        wait_cyc(4);
        chk({7'h0, fail_oe_n_o[0]}, 8'h00);
        wr_reg(ADDR_STAT, 8'h01);
        wait_cyc(4);
        chk({7'h0, fail_oe_n_o[0]}, 8'h00);
        pulse(1);
        wr_reg(ADDR_STAT, 8'h01);
        wait_cyc(4);
        chk({5'h0, fail_oe_n_o}, 8'h07);
        do_reset();
        hw_cfg_i <= 2'h1;
        pulse(0);
        wait_cyc(4);
        chk({7'h0, fail_oe_n_o[0]}, 8'h00);
        rd_reg(ADDR_STAT);
        chk({6'h0, rd[STAT_WDF], rd[STAT_FAIL]}, 8'h02);
        mode_i <= FOG_SLEEP;
        wait_cyc(3);
        mode_i <= FOG_NORMAL;
        rd_reg(ADDR_STAT);
        chk({7'h0, rd[STAT_WDF]}, 8'h00);
        pulse(0);
        mode_i <= FOG_STOP;
        wd_off_stop_i <= 1'b1;
        wait_cyc(3);
        mode_i <= FOG_NORMAL;
        wd_off_stop_i <= 1'b0;
        rd_reg(ADDR_STAT);
        chk({7'h0, rd[STAT_WDF]}, 8'h00);
        hw_cfg_i <= 2'h0;
        $display("test watchdog done");
        do_reset();
        wr_reg(ADDR_GPIO, 8'h14);
        wait_cyc(3);
        chk({6'h0, hs_drive_o}, 8'h01);
        rd_reg(ADDR_LVL);
        chk({7'h0, rd[0]}, 8'h01);
        mode_i <= FOG_RESTART;
        wait_cyc(3);
        chk({6'h0, hs_drive_o}, 8'h00);
        wr_reg(ADDR_GPIO, 8'h00);
        mode_i <= FOG_NORMAL;
        wait_cyc(3);
        chk({6'h0, hs_drive_o}, 8'h01);
        ext_low <= 2'b10;
        wait_cyc(1);
        chk({6'h0, wake_o}, 8'h02);
        wait_cyc(3);
        ext_low <= 2'b00;
        wait_cyc(4);
        rd_reg(ADDR_WAKE);
        chk({7'h0, rd[1]}, 8'h01);
        wr_reg(ADDR_WAKE, 8'h02);
        rd_reg(ADDR_WAKE);
        chk(rd, 8'h00);
        $display("test pins done");
        wr_reg(ADDR_GPIO, 8'h0b);
        wr_reg(ADDR_CTRL, 8'h01);
        wait_cyc(3);
        chk({5'h0, fail_oe_n_o}, 8'h04);
        rd_reg(ADDR_LVL);
        chk(rd, 8'h02);
        mode_i <= FOG_STOP;
        wr_reg(ADDR_CTRL, 8'h00);
        wait_cyc(3);
        chk({5'h0, fail_oe_n_o}, 8'h04);
        mode_i <= FOG_RESTART;
        wait_cyc(3);
        chk({5'h0, fail_oe_n_o}, 8'h06);
        mode_i <= FOG_SAFE;
        wait_cyc(3);
        chk({3'h0, fail_oe_n_o, hs_drive_o}, 8'h18);
        mode_i <= FOG_NORMAL;
        wait_cyc(3);
        chk({5'h0, fail_oe_n_o}, 8'h04);
        $display("test switches done");
        stop_test();
    end
endmodule
`default_nettype wire
